// ### verif/bus_trace_capture_controller_chk.sv
`timescale 1ns/1ps
`default_nettype none
module trace_chk #(
  parameter int ADDR_W = 24,
  parameter int DATA_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // target bus
  input wire logic bus_valid,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [DATA_W-1:0] bus_data,
  input wire logic prog_running,
  // record stream and status
  input wire logic rec_valid,
  input wire logic rec_tp,
  input wire logic [ADDR_W-1:0] rec_addr,
  input wire logic [DATA_W-1:0] rec_data,
  input wire logic capture_active,
  input wire logic trigger_point
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence req_seen;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence rec_taken;
    rec_valid;
  endsequence
  wait_answer_a: assert property (req_seen |=> !avs_waitrequest)
    else $error("bus request not answered next cycle");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  rdata_hold_a: assert property ($changed(avs_readdata) |-> $past(avs_read && avs_waitrequest))
    else $error("readdata moved without a read");
  rec_cause_a: assert property (rec_taken |-> $past(bus_valid && prog_running))
    else $error("record without a running bus cycle");
  rec_copy_a: assert property (rec_taken |-> rec_addr == $past(bus_addr) && rec_data == $past(bus_data))
    else $error("record content differs from bus cycle");
  rec_active_a: assert property (rec_taken |-> capture_active)
    else $error("record while capture idle");
  prog_stop_a: assert property (!prog_running |-> ##[1:4] !capture_active)
    else $error("capture survives program stop");
  tp_once_a: assert property (trigger_point |=> !trigger_point)
    else $error("trigger point on consecutive cycles");
  tp_tag_a: assert property (trigger_point |-> rec_valid && rec_tp)
    else $error("trigger point not on a tagged record");
endmodule
bind bus_trace_capture_controller trace_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_u (
  .clk, .nrst, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .bus_valid, .bus_addr,
  .bus_data, .prog_running, .rec_valid, .rec_tp, .rec_addr, .rec_data, .capture_active, .trigger_point
);
`default_nettype wire

// ### verif/bus_trace_capture_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bus_trace_capture_controller_tb;
  localparam int DEPTH = 2048;
  localparam int MEGA = 16;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic slow = 1'b0;
  logic run_in = 1'b1;
  logic [23:0] addr_in = 24'h00_0000;
  logic [15:0] data_in = 16'h0000;
  logic [15:0] ev_in = 16'h0000;
  logic [6:0] exc_in = 7'h00;
  logic bus_valid, prog_running, rec_valid, rec_tp, capture_active, trigger_point;
  logic [23:0] bus_addr, rec_addr;
  logic [15:0] bus_data, rec_data, event_hit;
  logic [6:0] exc_hit;
  logic [10:0] rec_index;
  logic [31:0] lfsr = 32'h8a86_a53b;
  logic [31:0] rd;
  logic [1:0] seg_q[$];
  int bad_count = 0;
  int checks_done = 0;
  int rec_cnt = 0;
  int post_cnt = 0;
  int sel;
  always #10 clk = ~clk;
  bus_trace_capture_controller #(.DEPTH(DEPTH), .MEGA(MEGA)) dut_u (.*);
  target_bus_model bus_u (.*);
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always @(posedge clk) begin
    lfsr <= lfsr_next(lfsr);
    data_in <= lfsr[15:0];
  end
  task automatic wrap_up();
    if (bad_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      bad_count++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [3:0] i, input logic [31:0] d);
    acc(1'b1, {2'b00, i, 2'b00}, d);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (capture_active !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (capture_active !== 1'b0) begin
      bad_count++;
      wrap_up();
    end
  endtask
  task automatic start(input logic [31:0] m);
    wr(4'h1, m);
    rec_cnt = 0;
    wr(4'h0, 32'h0000_0001);
  endtask
  // events held two cycles so every pulse meets a bus cycle
  task automatic pulse(input logic [15:0] e, input logic [6:0] x);
    ev_in <= e;
    exc_in <= x;
    repeat (2) @(posedge clk);
    ev_in <= 16'h0000;
    exc_in <= 7'h00;
    @(posedge clk);
  endtask
  task automatic tc(input logic [31:0] t, input logic [3:0] ri, input logic [31:0] rv, input logic [15:0] e0,
      input logic [15:0] e1, input logic [15:0] e2, input logic [6:0] x, input logic fire);
    wr(4'h2, t);
    wr(ri, rv);
    start(32'h0000_0002);
    if (fire) seg_q.push_back(2'd0);
    repeat (4) @(posedge clk);
    pulse(e0, x);
    pulse(e1, 7'h00);
    pulse(e2, 7'h00);
    repeat (6) @(posedge clk);
    chk("capture_active", 32'(!fire), 32'(capture_active));
    wr(4'h0, 32'h0000_0002);
    wait_idle();
  endtask
  always @(posedge clk) begin
    if (rec_valid === 1'b1) begin
      rec_cnt++;
      post_cnt++;
    end
    if (trigger_point === 1'b1) begin
      post_cnt = 0;
      if (seg_q.size() == 0) chk("spare trigger_point", 32'h0, 32'(trigger_point));
      else chk("trigger segment", 32'(seg_q.pop_front()), 32'(rec_index[10:9]));
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    acc(1'b0, 8'h08, 32'h0); chk("trig reset", 32'h0000_0001, rd);
    acc(1'b0, 8'h04, 32'h0); chk("mode reset", 32'h0000_0000, rd);
    acc(1'b0, 8'h40, 32'h0); chk("unmapped read", 32'h0000_0000, rd);
    wr(4'h3, 32'h0000_0001);
    slow <= 1'b1;
    start(32'h0000_0000);
    repeat (2200) @(posedge clk);
    pulse(16'h0001, 7'h00);
    repeat (2200) @(posedge clk);
    chk("circular active", 32'h1, 32'(capture_active));
    run_in <= 1'b0;
    wait_idle();
    run_in <= 1'b1;
    slow <= 1'b0;
    acc(1'b0, 8'h30, 32'h0); chk("wrap pointer", 32'(rec_cnt % DEPTH), rd);
    acc(1'b0, 8'h2c, 32'h0); chk("wrapped flag", 32'h1, 32'(rd[1]));
    start(32'h0000_0001);
    wr(4'h1, 32'h0000_0002);
    acc(1'b0, 8'h04, 32'h0); chk("mode frozen", 32'h0000_0001, rd);
    repeat (2100) @(posedge clk);
    wait_idle();
    chk("full count", 32'(DEPTH), 32'(rec_cnt));
    for (int s = 0; s < 6; s++) begin
      sel = (s == 5) ? 7 : s;
      start(32'h0000_0002 | 32'(sel << 4));
      seg_q.push_back(2'd0);
      repeat (20) @(posedge clk);
      pulse(16'h0001, 7'h00);
      wait_idle();
      chk("post count", 32'(((s > 4) ? 4 : s) * MEGA), 32'(post_cnt));
    end
    for (int m = 3; m < 5; m++) begin
      start(32'(m));
      for (int k = 0; k < 5; k++) begin
        if (m == 3 || k < 4) seg_q.push_back(2'(k % 4));
        repeat (300) @(posedge clk);
        pulse(16'h0001, 7'h00);
        repeat (260) @(posedge clk);
      end
      chk("window capture", 32'(m == 3), 32'(capture_active));
      if (m == 4) chk("post window", 32'h0000_0100, 32'(post_cnt));
      run_in <= 1'b0;
      wait_idle();
      run_in <= 1'b1;
    end
    tc(32'h1, 4'h3, 32'h20, 16'h20, 16'h0, 16'h0, 7'h0, 1'b1);
    tc(32'h0, 4'h3, 32'h20, 16'h20, 16'h0, 16'h0, 7'h0, 1'b0);
    tc(32'h1, 4'h3, 32'h20, 16'h20, 16'h0, 16'h0, 7'h0, 1'b1);
    tc(32'h2, 4'h4, 32'h3, 16'h1, 16'h2, 16'h0, 7'h0, 1'b1);
    tc(32'h12, 4'h4, 32'h3, 16'h1, 16'h2, 16'h0, 7'h0, 1'b0);
    tc(32'h12, 4'h4, 32'h3, 16'h3, 16'h0, 16'h0, 7'h0, 1'b1);
    wr(4'h6, 32'h0000_00ff);
    addr_in <= 24'h00_0180;
    tc(32'h22, 4'h7, 32'h2, 16'h4, 16'h0, 16'h0, 7'h0, 1'b0);
    addr_in <= 24'h00_0080;
    tc(32'h22, 4'h7, 32'h2, 16'h4, 16'h0, 16'h0, 7'h0, 1'b1);
    tc(32'h32, 4'h8, 32'h3a00_0021, 16'h4, 16'h2, 16'h4, 7'h0, 1'b1);
    tc(32'h32, 4'h8, 32'h3a00_0021, 16'h2, 16'h8, 16'h4, 7'h0, 1'b0);
    wr(4'h9, 32'h0060_0040);
    tc(32'h42, 4'ha, 32'h0000_0822, 16'h40, 16'h10, 16'h40, 7'h0, 1'b1);
    tc(32'h42, 4'ha, 32'h0000_0822, 16'h40, 16'h40, 16'h10, 7'h0, 1'b0);
    tc(32'h42, 4'ha, 32'h0003_1822, 16'h10, 16'h8, 16'h40, 7'h0, 1'b0);
    for (int i = 0; i < 7; i++) tc(32'h4 | (32'h100 << i), 4'h3, 32'h0, 16'h0, 16'h0, 16'h0, 7'(1 << i), 1'b1);
    tc(32'h104, 4'h3, 32'h0, 16'h0, 16'h0, 16'h0, 7'h02, 1'b0);
    chk("pending triggers", 32'h0, 32'(seg_q.size()));
    wrap_up();
  end
endmodule
`default_nettype wire

// ### verif/target_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module target_bus_model (
  // clock and bench control
  input wire logic clk,
  input wire logic slow,
  input wire logic run_in,
  input wire logic [23:0] addr_in,
  input wire logic [15:0] data_in,
  input wire logic [15:0] ev_in,
  input wire logic [6:0] exc_in,
  // target bus
  output logic bus_valid,
  output logic [23:0] bus_addr,
  output logic [15:0] bus_data,
  output logic prog_running,
  output logic [15:0] event_hit,
  output logic [6:0] exc_hit
);
  logic go;
  // slow cadence: a bus cycle every other clock; none once stopped
  assign go = run_in && !(slow && bus_valid);
  always_ff @(posedge clk) begin
    bus_valid <= go;
    // idle lines show the inverse so a stale value never passes as fresh
    bus_addr <= go ? addr_in : ~bus_addr;
    bus_data <= go ? data_in : ~bus_data;
    event_hit <= go ? ev_in : 16'h0000;
    exc_hit <= go ? exc_in : 7'h00;
    prog_running <= run_in;
  end
endmodule
`default_nettype wire

// ### verilog/bus_trace_capture_controller.sv
// How it works
// - memory holds 4M records; circular mode overwrites oldest and keeps going
// - circular mode records until the target program stops
// - stop-when-full mode halts when memory fills, no overwrite
// - delayed-stop mode halts only capture a set count after trigger
// - delay choices are 0,1M,2M,3M,4M cycles, zero after reset
// - window modes keep 255 before, trigger cycle, 256 after
// - repeat-until-stop keeps capturing windows until break or forced stop
// - repeat-until-full keeps capturing windows until the last segment fills, no overwrite
// - consecutive trigger cycles tag only the first of the run
// - triggers only in delayed and window modes, delay only delayed mode
// - trigger logic offers at most 16 event points
// - OR, combined and exception groups enable independently, any fires
// - OR group enabled at reset, fires on any selected event
// - combined group off at reset, runs one of five types
// - accumulated AND remembers seen events, fires when all seen
// - simultaneous AND fires when all selected events coincide
// - address-range fires on selected event inside address range
// - sequential steps up to six stages forward, reset event rewinds
// - three-state machine with nine paths plus reset event
// - seven exception inputs each selectable as trigger source
`include "trace_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module bus_trace_capture_controller #(
  parameter int DEPTH = `TR_DEPTH,
  parameter int MEGA = `TR_MEGA,
  parameter int ADDR_W = 24,
  parameter int DATA_W = 16,
  parameter int N_EV = `TR_N_EVENTS
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // avalon-mm register slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // target bus cycles
  input wire logic bus_valid,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [DATA_W-1:0] bus_data,
  input wire logic prog_running,
  input wire logic [N_EV-1:0] event_hit,
  input wire logic [`TR_N_EXC-1:0] exc_hit,
  // trace record stream
  output logic rec_valid,
  output logic [$clog2(DEPTH)-1:0] rec_index,
  output logic rec_tp,
  output logic [ADDR_W-1:0] rec_addr,
  output logic [DATA_W-1:0] rec_data,
  // status
  output logic capture_active,
  output logic trigger_point
);
  localparam int AW = $clog2(DEPTH);
  localparam int WB = `TR_WIN_BITS;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] POST_LAST = (AW+1)'(`TR_WIN_POST - 1);

  function automatic logic [31:0] apply_be(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] cfg_mask(input logic [3:0] i);
    case (i)
      `TR_IDX_MODE: cfg_mask = `TR_MSK_MODE;
      `TR_IDX_TRIG: cfg_mask = `TR_MSK_TRIG;
      `TR_IDX_OR_MASK, `TR_IDX_AND_MASK: cfg_mask = `TR_MSK_EVMASK;
      `TR_IDX_RANGE_LO, `TR_IDX_RANGE_HI: cfg_mask = `TR_MSK_RANGE;
      `TR_IDX_SUB_EV: cfg_mask = `TR_MSK_SUB;
      `TR_IDX_STT_CFG: cfg_mask = `TR_MSK_STT_CFG;
      default: cfg_mask = `TR_MSK_ALL;
    endcase
  endfunction

  // register slave
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [31:0] cfg_reg [1:10];
  logic [3:0] widx;
  logic wr_go;
  logic start_req;
  logic stop_req;
  logic [31:0] status_word;
  logic [31:0] rd_mux;
  trace_pkg::cap_state_e cap_state_reg;
  logic [AW-1:0] wptr_reg;
  logic full_reg;
  logic trig_seen_reg;

  assign widx = avs_address[5:2];
  assign wr_go = avs_write && !wait_reg && (avs_address[7:6] == 2'b00);
  assign start_req = wr_go && widx == `TR_IDX_CTRL && avs_byteenable[0] && avs_writedata[`TR_CTRL_START];
  assign stop_req = wr_go && widx == `TR_IDX_CTRL && avs_byteenable[0] && avs_writedata[`TR_CTRL_STOP];
  assign status_word = {28'h000_0000, trig_seen_reg, cap_state_reg == trace_pkg::CAP_POST, full_reg,
    cap_state_reg != trace_pkg::CAP_IDLE};

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (avs_address[7:6] == 2'b00) begin
      if (widx >= `TR_IDX_MODE && widx <= `TR_IDX_STT_CFG) begin
        rd_mux = cfg_reg[widx];
      end else if (widx == `TR_IDX_STATUS) begin
        rd_mux = status_word;
      end else if (widx == `TR_IDX_WPTR) begin
        rd_mux = 32'(wptr_reg);
      end
    end
  end

  // one wait state; the access completes at the edge where waitrequest is low
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else if ((avs_read || avs_write) && wait_reg) begin
      wait_reg <= 1'b0;
      // hold read data across writes so a result stands until the next read
      if (avs_read) begin
        rdata_reg <= rd_mux;
      end
    end else begin
      wait_reg <= 1'b1;
    end
  end
  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;

  // config writes refused while capturing so a run sees one setup
  genvar gi;
  generate
    for (gi = 1; gi <= 10; gi++) begin : g_cfg
      always_ff @(posedge clk) begin
        if (!nrst) begin
          cfg_reg[gi] <= (4'(gi) == `TR_IDX_TRIG) ? `TR_RST_TRIG : `TR_RST_ZERO;
        end else if (wr_go && widx == 4'(gi) && cap_state_reg == trace_pkg::CAP_IDLE) begin
          cfg_reg[gi] <= apply_be(cfg_reg[gi], avs_writedata, avs_byteenable) & cfg_mask(4'(gi));
        end
      end
    end
  endgenerate

  // decoded configuration
  trace_pkg::trace_mode_e mode;
  trace_pkg::comb_e comb_type;
  logic [2:0] dsel;
  logic [AW:0] dly;
  logic or_en, comb_en, exc_en;
  logic [N_EV-1:0] or_mask, and_mask;
  logic [`TR_N_EXC-1:0] exc_mask;
  logic [31:0] seq_w, stt_ev_w, stt_cfg_w;
  logic trig_mode, win_mode;

  assign mode = trace_pkg::trace_mode_e'(cfg_reg[`TR_IDX_MODE][2:0]);
  assign dsel = (cfg_reg[`TR_IDX_MODE][6:4] > `TR_DSEL_MAX) ? `TR_DSEL_MAX : cfg_reg[`TR_IDX_MODE][6:4];
  // one bit wider than the pointer so a full-depth delay still fits
  assign dly = (AW+1)'(MEGA) * (AW+1)'(dsel);
  assign or_en = cfg_reg[`TR_IDX_TRIG][`TR_TRIG_OR_EN];
  assign comb_en = cfg_reg[`TR_IDX_TRIG][`TR_TRIG_COMB_EN];
  assign exc_en = cfg_reg[`TR_IDX_TRIG][`TR_TRIG_EXC_EN];
  assign comb_type = trace_pkg::comb_e'(cfg_reg[`TR_IDX_TRIG][6:4]);
  assign exc_mask = cfg_reg[`TR_IDX_TRIG][8 +: `TR_N_EXC];
  assign or_mask = cfg_reg[`TR_IDX_OR_MASK][N_EV-1:0];
  assign and_mask = cfg_reg[`TR_IDX_AND_MASK][N_EV-1:0];
  assign seq_w = cfg_reg[`TR_IDX_SEQ];
  assign stt_ev_w = cfg_reg[`TR_IDX_STT_EV];
  assign stt_cfg_w = cfg_reg[`TR_IDX_STT_CFG];
  assign win_mode = mode == trace_pkg::MODE_REP_STOP || mode == trace_pkg::MODE_REP_FULL;
  assign trig_mode = win_mode || mode == trace_pkg::MODE_AROUND;

  // combined-condition units
  logic [N_EV-1:0] acc_seen_reg;
  logic [2:0] seq_stage_reg;
  logic [1:0] stt_reg;
  logic [2:0] seq_cnt;
  logic [3:0] seq_ev_idx;
  logic acc_hit, sim_hit, sub_hit, seq_adv, seq_rst, seq_hit;
  logic stt_rst, stt_move, stt_hit;
  logic [1:0] stt_next;
  logic [3:0] path_ev;
  logic comb_hit, trig_raw, trig_prev_reg, tp_first, step;

  assign step = bus_valid && cap_state_reg != trace_pkg::CAP_IDLE;
  assign acc_hit = and_mask != '0 && ((acc_seen_reg | event_hit) & and_mask) == and_mask;
  assign sim_hit = and_mask != '0 && (event_hit & and_mask) == and_mask;
  assign sub_hit = event_hit[cfg_reg[`TR_IDX_SUB_EV][3:0]] && bus_addr >= cfg_reg[`TR_IDX_RANGE_LO][ADDR_W-1:0]
    && bus_addr <= cfg_reg[`TR_IDX_RANGE_HI][ADDR_W-1:0];
  assign seq_cnt = (seq_w[`TR_SEQ_CNT +: 3] == 3'h0) ? 3'h1 :
    (seq_w[`TR_SEQ_CNT +: 3] > 3'(`TR_SEQ_STAGES)) ? 3'(`TR_SEQ_STAGES) : seq_w[`TR_SEQ_CNT +: 3];
  assign seq_ev_idx = seq_w[{seq_stage_reg, 2'b00} +: 4];
  assign seq_rst = seq_w[`TR_SEQ_RST_EN] && event_hit[seq_w[`TR_SEQ_RST_EV +: 4]];
  assign seq_adv = !seq_rst && event_hit[seq_ev_idx];
  assign seq_hit = seq_adv && seq_stage_reg == seq_cnt - 3'h1;
  assign stt_rst = stt_cfg_w[`TR_STT_RST_EN] && event_hit[stt_cfg_w[`TR_STT_RST_EV +: 4]];

  // lowest-numbered enabled path out of the current state wins
  always_comb begin
    stt_move = 1'b0;
    stt_next = stt_reg;
    path_ev = 4'h0;
    for (int p = `TR_STT_PATHS - 1; p >= 0; p--) begin
      path_ev = (p == 8) ? stt_cfg_w[`TR_STT_EV8 +: 4] : stt_ev_w[(p % 8)*4 +: 4];
      if (stt_cfg_w[p] && 2'(p / 3) == stt_reg && event_hit[path_ev]) begin
        stt_move = 1'b1;
        stt_next = 2'(p % 3);
      end
    end
  end
  assign stt_hit = !stt_rst && stt_move && stt_next == stt_cfg_w[`TR_STT_TGT +: 2];

  always_comb begin
    case (comb_type)
      trace_pkg::COMB_ACC: comb_hit = acc_hit;
      trace_pkg::COMB_SIM: comb_hit = sim_hit;
      trace_pkg::COMB_SUB: comb_hit = sub_hit;
      trace_pkg::COMB_SEQ: comb_hit = seq_hit;
      trace_pkg::COMB_STT: comb_hit = stt_hit;
      default: comb_hit = 1'b0;
    endcase
  end

  assign trig_raw = bus_valid && trig_mode && ((or_en && |(event_hit & or_mask))
    || (comb_en && comb_hit) || (exc_en && |(exc_hit & exc_mask)));
  assign tp_first = trig_raw && !trig_prev_reg;

  // only real bus cycles advance the run detector, so idle gaps do not split a run

  always_ff @(posedge clk) begin
    if (!nrst || start_req) begin
      trig_prev_reg <= 1'b0;
    end else if (bus_valid) begin
      trig_prev_reg <= trig_raw;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || start_req) begin
      acc_seen_reg <= '0;
    end else if (step && comb_en && comb_type == trace_pkg::COMB_ACC) begin
      acc_seen_reg <= acc_hit ? '0 : (acc_seen_reg | (event_hit & and_mask));
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || start_req) begin
      seq_stage_reg <= 3'h0;
    end else if (step && comb_en && comb_type == trace_pkg::COMB_SEQ) begin
      if (seq_rst || seq_hit) begin
        seq_stage_reg <= 3'h0;
      end else if (seq_adv) begin
        seq_stage_reg <= seq_stage_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || start_req) begin
      stt_reg <= 2'h0;
    end else if (step && comb_en && comb_type == trace_pkg::COMB_STT) begin
      stt_reg <= stt_rst ? 2'h0 : stt_next;
    end
  end

  // capture sequencer; start outranks stop, and a program stop ends every mode
  // window modes keep pre-trigger history circular inside their own 512-slot segment
  logic [AW:0] dcnt_reg;
  logic [AW-1:0] win_next;
  assign win_next = {wptr_reg[AW-1:WB], wptr_reg[WB-1:0] + WB'(1)};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cap_state_reg <= trace_pkg::CAP_IDLE;
      wptr_reg <= '0;
      dcnt_reg <= '0;
      full_reg <= 1'b0;
      trig_seen_reg <= 1'b0;
    end else if (start_req) begin
      cap_state_reg <= trace_pkg::CAP_PRE;
      wptr_reg <= '0;
      dcnt_reg <= '0;
      full_reg <= 1'b0;
      trig_seen_reg <= 1'b0;
    end else if (cap_state_reg != trace_pkg::CAP_IDLE && (stop_req || !prog_running)) begin
      cap_state_reg <= trace_pkg::CAP_IDLE;
    end else if (step) begin
      case (cap_state_reg)
        trace_pkg::CAP_PRE: begin
          wptr_reg <= win_mode ? win_next : wptr_reg + AW'(1);
          if (!win_mode && wptr_reg == LAST) begin
            full_reg <= 1'b1;
          end
          if (mode == trace_pkg::MODE_FULL && wptr_reg == LAST) begin
            cap_state_reg <= trace_pkg::CAP_IDLE;
          end else if (tp_first) begin
            trig_seen_reg <= 1'b1;
            dcnt_reg <= '0;
            cap_state_reg <= (!win_mode && dly == '0) ? trace_pkg::CAP_IDLE : trace_pkg::CAP_POST;
          end
        end
        trace_pkg::CAP_POST: begin
          dcnt_reg <= dcnt_reg + (AW+1)'(1);
          if (!win_mode) begin
            wptr_reg <= wptr_reg + AW'(1);
            if (wptr_reg == LAST) begin
              full_reg <= 1'b1;
            end
            if (dcnt_reg + (AW+1)'(1) == dly) begin
              cap_state_reg <= trace_pkg::CAP_IDLE;
            end
          end else if (dcnt_reg == POST_LAST) begin
            wptr_reg <= {wptr_reg[AW-1:WB] + (AW-WB)'(1), WB'(0)};
            cap_state_reg <= trace_pkg::CAP_PRE;
            if (&wptr_reg[AW-1:WB]) begin
              full_reg <= 1'b1;
              if (mode == trace_pkg::MODE_REP_FULL) begin
                cap_state_reg <= trace_pkg::CAP_IDLE;
              end
            end
          end else begin
            wptr_reg <= win_next;
          end
        end
        default: cap_state_reg <= trace_pkg::CAP_IDLE;
      endcase
    end
  end

  // records and trigger tags share one gate so a tag never lands without its record
  logic rec_go;
  assign rec_go = step && !start_req && !stop_req && prog_running;

  // record stream and status outputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rec_valid <= 1'b0;
      rec_index <= '0;
      rec_tp <= 1'b0;
      rec_addr <= '0;
      rec_data <= '0;
      trigger_point <= 1'b0;
    end else begin
      rec_valid <= rec_go;
      rec_index <= wptr_reg;
      rec_tp <= rec_go && cap_state_reg == trace_pkg::CAP_PRE && tp_first;
      rec_addr <= bus_addr;
      rec_data <= bus_data;
      trigger_point <= rec_go && cap_state_reg == trace_pkg::CAP_PRE && tp_first;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      capture_active <= 1'b0;
    end else begin
      capture_active <= cap_state_reg != trace_pkg::CAP_IDLE;
    end
  end
endmodule
`default_nettype wire

// ### verilog/trace_cfg.svh
`ifndef TRACE_CFG_SVH
`define TRACE_CFG_SVH
// capture geometry and timing counts
`define TR_DEPTH 4194304
`define TR_MEGA 1048576
`define TR_WIN_BITS 9
`define TR_WIN_PRE 255
`define TR_WIN_POST 256
`define TR_N_EVENTS 16
`define TR_N_EXC 7
`define TR_SEQ_STAGES 6
`define TR_STT_PATHS 9
`define TR_DSEL_MAX 3'h4
// register word indices (byte address = index * 4)
`define TR_IDX_CTRL 4'h0
`define TR_IDX_MODE 4'h1
`define TR_IDX_TRIG 4'h2
`define TR_IDX_OR_MASK 4'h3
`define TR_IDX_AND_MASK 4'h4
`define TR_IDX_RANGE_LO 4'h5
`define TR_IDX_RANGE_HI 4'h6
`define TR_IDX_SUB_EV 4'h7
`define TR_IDX_SEQ 4'h8
`define TR_IDX_STT_EV 4'h9
`define TR_IDX_STT_CFG 4'ha
`define TR_IDX_STATUS 4'hb
`define TR_IDX_WPTR 4'hc
// field positions
`define TR_CTRL_START 0
`define TR_CTRL_STOP 1
`define TR_TRIG_OR_EN 0
`define TR_TRIG_COMB_EN 1
`define TR_TRIG_EXC_EN 2
`define TR_SEQ_CNT 24
`define TR_SEQ_RST_EN 27
`define TR_SEQ_RST_EV 28
`define TR_STT_TGT 10
`define TR_STT_RST_EN 12
`define TR_STT_RST_EV 16
`define TR_STT_EV8 20
// reset values and writable masks
`define TR_RST_ZERO 32'h0000_0000
`define TR_RST_TRIG 32'h0000_0001
`define TR_MSK_MODE 32'h0000_0077
`define TR_MSK_TRIG 32'h0000_7f77
`define TR_MSK_EVMASK 32'h0000_ffff
`define TR_MSK_RANGE 32'h00ff_ffff
`define TR_MSK_SUB 32'h0000_000f
`define TR_MSK_ALL 32'hffff_ffff
`define TR_MSK_STT_CFG 32'h00ff_1dff
`endif

// ### verilog/trace_pkg.sv
package trace_pkg;
  typedef enum logic [2:0] {
    MODE_CIRC = 3'b000,
    MODE_FULL = 3'b001,
    MODE_AROUND = 3'b010,
    MODE_REP_STOP = 3'b011,
    MODE_REP_FULL = 3'b100
  } trace_mode_e;
  typedef enum logic [2:0] {
    COMB_ACC = 3'b000,
    COMB_SIM = 3'b001,
    COMB_SUB = 3'b010,
    COMB_SEQ = 3'b011,
    COMB_STT = 3'b100
  } comb_e;
  typedef enum logic [1:0] {
    CAP_IDLE = 2'b00,
    CAP_PRE = 2'b01,
    CAP_POST = 2'b10
  } cap_state_e;
endpackage
